// file: io_port_defines.svh
// Notes on behaviour
// - Sixteen pins in four four-bit ports A to D, each input or output.
// - Every pin has its own direction bit, independent of the others.
// - Input build choice per pin: fixed pull-up, none, or software pull-up.
// - Software pull-up pins wake only on a falling level change.
// - Fixed pull-up pins wake on both rising and falling changes.
// - One weak or strong pull-up strength applies to all pins.
// - Output build choice per pin: normal, large or constant sink, normal source.
// - Port A bit 2 may emit an infrared carrier set by a five-bit option.
// - A build option picks carrier during data high or during data low.
// - Port A bit 3 as external reset resets the device while low.
// - Port B: bit 0 chip select, bit 1 SCK, bit 2 MOSI, bit 3 MISO.
// - Device drives SCK and MOSI, samples MISO returned by the memory.
// - Serial clock rate is a build option of 8, 4, 2 or 1 MHz.
// - Port A bits 0 and 1 feed comparator; high when positive exceeds negative.
// - Comparator flag sets on rising edge of comparator output, not level.
// - Writing zero clears the flag; it sets again only after a re-cross.
`ifndef IO_PORT_DEFINES_SVH
`define IO_PORT_DEFINES_SVH
`define IO_NUM_PORTS 4
`define IO_PORT_WIDTH 4
`define IO_NUM_PINS 16
`define IO_BIT_CMP_POS 0
`define IO_BIT_CMP_NEG 1
`define IO_BIT_INFRARED 2
`define IO_BIT_EXT_RESET 3
`define IO_SPI_BIT_SCK 5
`define IO_SPI_BIT_MOSI 6
`define IO_SPI_BIT_MISO 7
`define IO_IR_DIV_BASE 6'h20
`endif

// file: io_port_pkg.sv
package io_port_pkg;
  // Input build options per pin.
  typedef enum logic [1:0] {
    pull_fixed = 2'b00,
    pull_none = 2'b01,
    pull_soft = 2'b10
  } pull_opt_t;
  // Output drive build options per pin.
  typedef enum logic [1:0] {
    sink_normal = 2'b00,
    sink_large = 2'b01,
    sink_constant = 2'b10
  } drive_opt_t;
  // Serial clock rate options.
  typedef enum logic [1:0] {
    sck_8mhz = 2'b00,
    sck_4mhz = 2'b01,
    sck_2mhz = 2'b10,
    sck_1mhz = 2'b11
  } sck_rate_t;
  // Serial engine request towards the pins.
  typedef struct packed {
    logic active;
    logic mosi;
  } spi_req_t;
  // Per-pin pad controls.
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] pull_en;
  } pad_ctrl_t;
endpackage : io_port_pkg

// file: io_port_shared_pin_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_port_defines.svh"
module io_port_shared_pin_logic
  import io_port_pkg::*;
#(
  parameter logic [31:0] PULL_OPT = 32'h0,
  parameter logic [31:0] DRIVE_OPT = 32'h0,
  parameter logic STRONG_PULL = 1'b0,
  parameter logic IR_ENABLE = 1'b0,
  parameter logic [4:0] IR_FREQ = 5'h00,
  parameter logic IR_ON_HIGH = 1'b1,
  parameter logic EXT_RESET_EN = 1'b0,
  parameter logic CMP_ENABLE = 1'b0,
  parameter logic [1:0] SCK_RATE = 2'h0
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] pull_en,
  output logic [31:0] drive_sel,
  output logic strong_pull,
  input wire logic [15:0] dir_out,
  input wire logic [15:0] data_out,
  input wire logic [15:0] pull_sw,
  input wire spi_req_t spi_req,
  input wire logic cmp_result,
  input wire logic cmp_flag_clr,
  output logic cmp_flag,
  output logic [15:0] pin_state,
  output logic spi_miso,
  output logic spi_sck_tick,
  output logic wake,
  output logic ext_reset_req
);
  // Refuse build options that no pin decoder can serve.
  initial begin
    for (int i = 0; i < 16; i++) begin
      if (PULL_OPT[2*i +: 2] == 2'h3) $error("bad pull option");
      if (DRIVE_OPT[2*i +: 2] == 2'h3) $error("bad drive option");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode one pin's input option from the packed option word.
  function automatic pull_opt_t pin_pull(input logic [31:0] opt, input int idx);
    pull_opt_t p;
    p = pull_opt_t'(opt[2*idx +: 2]);
    return p;
  endfunction : pin_pull

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser and previous sample.
  logic [15:0] sync1;
  logic [15:0] sync2;
  logic [15:0] prev;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 16'hFFFF;
      sync2 <= 16'hFFFF;
      prev <= 16'hFFFF;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Pin state seen by software.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) pin_state <= 16'h0000;
    else pin_state <= sync2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup from level changes on input pins.
  logic [15:0] fall;
  logic [15:0] rise;
  logic [15:0] next_wake_hit;
  assign fall = prev & ~sync2;
  assign rise = ~prev & sync2;
  always_comb begin
    next_wake_hit = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (!dir_out[i]) begin
        case (pin_pull(PULL_OPT, i))
          pull_soft: next_wake_hit[i] = fall[i];
          pull_fixed: next_wake_hit[i] = fall[i] | rise[i];
          default: next_wake_hit[i] = 1'b0;
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) wake <= 1'b0;
    else wake <= |next_wake_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up enables and drive strength selects.
  logic [15:0] next_pull;
  always_comb begin
    next_pull = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      case (pin_pull(PULL_OPT, i))
        pull_fixed: next_pull[i] = !dir_out[i];
        pull_soft: next_pull[i] = !dir_out[i] && pull_sw[i];
        default: next_pull[i] = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pull_en <= 16'h0000;
      drive_sel <= 32'h0;
      strong_pull <= 1'b0;
    end else begin
      pull_en <= next_pull;
      drive_sel <= DRIVE_OPT;
      strong_pull <= STRONG_PULL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Infrared carrier divider: half period is base plus option, in cycles.
  logic [5:0] ir_cnt;
  logic ir_carrier;
  logic [5:0] ir_half;
  assign ir_half = `IO_IR_DIV_BASE + {1'b0, IR_FREQ};
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ir_cnt <= 6'h00;
      ir_carrier <= 1'b0;
    end else if (ir_cnt >= ir_half - 6'h01) begin
      ir_cnt <= 6'h00;
      ir_carrier <= ~ir_carrier;
    end else begin
      ir_cnt <= ir_cnt + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock enable divider: one tick every 15, 31, 63 or 125 system clock cycles.
  logic [7:0] sck_cnt;
  logic [7:0] sck_top;
  always_comb begin
    case (sck_rate_t'(SCK_RATE))
      sck_8mhz: sck_top = 8'h0E;
      sck_4mhz: sck_top = 8'h1E;
      sck_2mhz: sck_top = 8'h3E;
      default: sck_top = 8'h7C;
    endcase
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sck_cnt <= 8'h00;
      spi_sck_tick <= 1'b0;
    end else if (sck_cnt >= sck_top) begin
      sck_cnt <= 8'h00;
      spi_sck_tick <= 1'b1;
    end else begin
      sck_cnt <= sck_cnt + 8'h01;
      spi_sck_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad output and enable with shared functions overlaid.
  logic [15:0] next_out;
  logic [15:0] next_oe;
  always_comb begin
    next_out = data_out;
    next_oe = dir_out;
    if (IR_ENABLE) begin
      next_oe[`IO_BIT_INFRARED] = 1'b1;
      next_out[`IO_BIT_INFRARED] =
        (data_out[`IO_BIT_INFRARED] == IR_ON_HIGH) ? ir_carrier : 1'b0;
    end
    if (EXT_RESET_EN) next_oe[`IO_BIT_EXT_RESET] = 1'b0;
    if (CMP_ENABLE) begin
      next_oe[`IO_BIT_CMP_POS] = 1'b0;
      next_oe[`IO_BIT_CMP_NEG] = 1'b0;
    end
    if (spi_req.active) begin
      next_oe[`IO_SPI_BIT_SCK] = 1'b1;
      next_out[`IO_SPI_BIT_SCK] = spi_sck_tick;
      next_oe[`IO_SPI_BIT_MOSI] = 1'b1;
      next_out[`IO_SPI_BIT_MOSI] = spi_req.mosi;
      next_oe[`IO_SPI_BIT_MISO] = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_out <= 16'h0000;
      pin_oe <= 16'h0000;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) spi_miso <= 1'b0;
    else spi_miso <= sync2[`IO_SPI_BIT_MISO];
  end

  ////////////////////////////////////////////////////////////////////////////
  // External reset request while the pin is low.
  // external reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) ext_reset_req <= 1'b0;
    else ext_reset_req <= EXT_RESET_EN && !sync2[`IO_BIT_EXT_RESET];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator result synchronised, flag set on its rising edge.
  logic cmp_s1;
  logic cmp_s2;
  logic cmp_prev;
  logic cmp_rise;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_prev <= 1'b0;
    end else begin
      cmp_s1 <= cmp_result;
      cmp_s2 <= cmp_s1;
      cmp_prev <= cmp_s2;
    end
  end
  assign cmp_rise = CMP_ENABLE && cmp_s2 && !cmp_prev;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) cmp_flag <= 1'b0;
    else if (cmp_rise) cmp_flag <= 1'b1;
    else if (cmp_flag_clr) cmp_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Per-pin masks of the input build options, read only by the checks below.
  logic [15:0] soft_mask;
  logic [15:0] fixed_mask;
  always_comb begin
    soft_mask = 16'h0000;
    fixed_mask = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      soft_mask[i] = (pin_pull(PULL_OPT, i) == pull_soft);
      fixed_mask[i] = (pin_pull(PULL_OPT, i) == pull_fixed);
    end
  end
  sequence s_rise;
    CMP_ENABLE && cmp_s2 && !cmp_prev;
  endsequence
  AST_CMP_SET: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_rise |=> cmp_flag) else $error("flag not set on edge");
  AST_CMP_STAY: assert property (@(posedge clk_sys) disable iff (!nrst)
    cmp_flag_clr && !cmp_rise |=> !cmp_flag) else $error("flag not cleared");
  AST_CMP_LEVEL: assert property (@(posedge clk_sys) disable iff (!nrst)
    !cmp_flag && !cmp_rise |=> !cmp_flag) else $error("flag set by level");
  AST_WAKE_SOFT: assert property (@(posedge clk_sys) disable iff (!nrst)
    |(fall & soft_mask & ~dir_out) |=> wake) else $error("no wake on fall");
  AST_WAKE_FIXED: assert property (@(posedge clk_sys) disable iff (!nrst)
    |((fall | rise) & fixed_mask & ~dir_out) |=> wake) else $error("no wake on change");
  AST_EXT_RST: assert property (@(posedge clk_sys) disable iff (!nrst)
    EXT_RESET_EN && !sync2[3] |=> ext_reset_req) else $error("no reset request");
  AST_EXT_REL: assert property (@(posedge clk_sys) disable iff (!nrst)
    !EXT_RESET_EN || sync2[3] |=> !ext_reset_req) else $error("reset request stuck");
  AST_DIR: assert property (@(posedge clk_sys) disable iff (!nrst)
    !spi_req.active
    |=> pin_oe[15:4] == $past(dir_out[15:4])) else $error("direction mismatch");
  AST_MOSI: assert property (@(posedge clk_sys) disable iff (!nrst)
    spi_req.active |=> pin_oe[6] && pin_out[6] == $past(spi_req.mosi))
    else $error("mosi not driven");
  AST_MISO: assert property (@(posedge clk_sys) disable iff (!nrst)
    spi_req.active |=> !pin_oe[7]) else $error("miso driven");
  AST_TICK: assert property (@(posedge clk_sys) disable iff (!nrst)
    spi_sck_tick |=> !spi_sck_tick) else $error("tick too long");
  AST_SCK_PIN: assert property (@(posedge clk_sys) disable iff (!nrst)
    spi_req.active |=> pin_oe[5] && pin_out[5] == $past(spi_sck_tick))
    else $error("serial clock pin wrong");
  AST_IR_QUIET: assert property (@(posedge clk_sys) disable iff (!nrst)
    IR_ENABLE && data_out[2] != IR_ON_HIGH |=> !pin_out[2])
    else $error("carrier in wrong data level");
endmodule : io_port_shared_pin_logic
`default_nettype wire

// file: io_far_side.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module io_far_side (
  input wire logic clk_sys,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pull_en,
  input wire logic [15:0] key_low,
  input wire logic [15:0] key_high,
  input wire logic mem_bit,
  output logic [15:0] pin_in
);
  logic [15:0] wobble = 16'h5555;
  logic mem_sel;

  // A floating pin wanders every cycle rather than keeping its last level.
  always_ff @(posedge clk_sys) begin
    wobble <= ~wobble;
  end

  // select from plain pin.
  // The memory answers only while port B bit 0 drives its select low.
  assign mem_sel = pin_oe[4] & ~pin_out[4];

  // pin level resolve.
  // The driver wins, then a key held low, then the memory, then a key held high or the pull-up.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (key_low[i]) begin
        pin_in[i] = 1'b0;
      end else if (i == 7 && mem_sel) begin
        pin_in[i] = mem_bit;
      end else if (key_high[i] | pull_en[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = wobble[i];
      end
    end
  end
endmodule : io_far_side
`default_nettype wire

// file: tb_io_port_shared_pin_logic.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
////////////////////////////////////////////////////////////////////////
module tb_io_port_shared_pin_logic;
  import io_port_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] pin_in, pin_out, pin_oe, pull_en, pin_state, dir_out, data_out, pull_sw;
  logic [15:0] key_low, key_high;
  logic [31:0] drive_sel;
  logic strong_pull, cmp_result, cmp_flag_clr, cmp_flag, spi_miso, spi_sck_tick;
  logic wake, ext_reset_req, mem_bit;
  spi_req_t spi_req;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int gap;

  io_port_shared_pin_logic #(.PULL_OPT(32'h18), .DRIVE_OPT(32'h24), .IR_ENABLE(1'b1),
    .EXT_RESET_EN(1'b1), .CMP_ENABLE(1'b1)) uut (.clk_sys(clk_sys),
    .nrst(nrst), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
    .drive_sel(drive_sel), .strong_pull(strong_pull), .dir_out(dir_out),
    .data_out(data_out), .pull_sw(pull_sw), .spi_req(spi_req), .cmp_result(cmp_result),
    .cmp_flag_clr(cmp_flag_clr), .cmp_flag(cmp_flag), .pin_state(pin_state),
    .spi_miso(spi_miso), .spi_sck_tick(spi_sck_tick), .wake(wake),
    .ext_reset_req(ext_reset_req));

  io_far_side far (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_en(pull_en), .key_low(key_low), .key_high(key_high), .mem_bit(mem_bit),
    .pin_in(pin_in));

  // Free-running clock and a cycle ceiling that cuts a hang short.
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      test_done();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Lets n edges pass and settles past the last one.
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  // Moves one pin and checks the wake pulse and its exact cycle.
  task automatic pin_wake(input int b, input logic lvl, input logic exp);
    @(posedge clk_sys) key_low[b] <= !lvl;
    step(2);
    `CHK("wake early", 1'b0, wake)
    step(1);
    `CHK("wake", exp, wake)
    `CHK("pin state", lvl, pin_state[b])
    step(1);
    `CHK("wake end", 1'b0, wake)
  endtask : pin_wake

  // Lets settled cycles pass until the carrier pin shows lvl, at most 200.
  task automatic ir_wait(input logic lvl, output int n);
    n = 0;
    while (pin_out[2] !== lvl && n < 200) begin
      step(1);
      n++;
    end
  endtask : ir_wait

  // Main sequence of scenarios.
  initial begin
    {dir_out, data_out, key_low, mem_bit, cmp_result, cmp_flag_clr} = '0;
    pull_sw = 16'h0002;
    key_high = 16'h0004;
    spi_req = '0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    step(8);
    `CHK("strong", 1'b0, strong_pull)
    `CHK("drive", 32'h24, drive_sel)
    `CHK("pull", 16'hFFFB, pull_en)
    @(posedge clk_sys) pull_sw <= 16'h0000;
    step(2);
    `CHK("pull soft", 16'hFFF9, pull_en)
    @(posedge clk_sys) begin
      dir_out <= 16'hA500;
      data_out <= 16'h3C00;
      pull_sw <= 16'h0002;
    end
    step(1);
    `CHK("oe", 16'hA504, pin_oe)
    `CHK("out", 16'h2400, pin_out & pin_oe)
    step(3);
    `CHK("state", 8'h7E, pin_state[15:8])
    @(posedge clk_sys) dir_out <= 16'h0000;
    step(8);
    pin_wake(0, 1'b0, 1'b1);
    pin_wake(0, 1'b1, 1'b1);
    pin_wake(1, 1'b0, 1'b1);
    pin_wake(1, 1'b1, 1'b0);
    @(posedge clk_sys) key_low[3] <= 1'b1;
    step(5);
    `CHK("ext reset", 1'b1, ext_reset_req)
    @(posedge clk_sys) key_low[3] <= 1'b0;
    step(5);
    `CHK("ext release", 1'b0, ext_reset_req)
    @(posedge clk_sys) cmp_result <= 1'b1;
    step(2);
    `CHK("flag early", 1'b0, cmp_flag)
    step(1);
    `CHK("flag set", 1'b1, cmp_flag)
    @(posedge clk_sys) cmp_flag_clr <= 1'b1;
    @(posedge clk_sys) cmp_flag_clr <= 1'b0;
    step(6);
    `CHK("flag level", 1'b0, cmp_flag)
    @(posedge clk_sys) cmp_result <= 1'b0;
    step(6);
    `CHK("flag low", 1'b0, cmp_flag)
    @(posedge clk_sys) cmp_result <= 1'b1;
    step(4);
    `CHK("flag again", 1'b1, cmp_flag)
    @(posedge clk_sys) cmp_flag_clr <= 1'b1;
    @(posedge clk_sys) begin
      cmp_flag_clr <= 1'b0;
      cmp_result <= 1'b0;
    end
    step(6);
    `CHK("flag cleared", 1'b0, cmp_flag)
    @(posedge clk_sys) cmp_result <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys) cmp_flag_clr <= 1'b1;
    @(posedge clk_sys) cmp_flag_clr <= 1'b0;
    step(1);
    `CHK("flag set wins", 1'b1, cmp_flag)
    @(posedge clk_sys) begin
      dir_out[4] <= 1'b1;
      spi_req <= 2'b11;
      mem_bit <= 1'b1;
    end
    step(5);
    `CHK("spi oe", 2'b11, pin_oe[6:5])
    `CHK("mosi", 1'b1, pin_out[6])
    `CHK("miso hi", 1'b1, spi_miso)
    @(posedge clk_sys) mem_bit <= 1'b0;
    step(5);
    `CHK("miso lo", 1'b0, spi_miso)
    gap = 0;
    while (spi_sck_tick !== 1'b1 && gap < 200) begin
      step(1);
      gap++;
    end
    gap = 0;
    do begin
      step(1);
      gap++;
    end while (spi_sck_tick !== 1'b1 && gap < 200);
    `CHK("tick gap", 15, gap)
    step(1);
    `CHK("sck pin", 1'b1, pin_out[5])
    @(posedge clk_sys) data_out[2] <= 1'b1;
    step(1);
    `CHK("ir oe", 1'b1, pin_oe[2])
    ir_wait(1'b0, gap);
    ir_wait(1'b1, gap);
    step(1);
    ir_wait(1'b0, gap);
    `CHK("ir half", 32, gap + 1)
    @(posedge clk_sys) data_out[2] <= 1'b0;
    step(2);
    ir_wait(1'b1, gap);
    `CHK("ir quiet", 200, gap)
    test_done();
  end
endmodule : tb_io_port_shared_pin_logic
`default_nettype wire
